// ---- bench/ehp_assertions.sv ----
// Concurrent checks on the link between the host and device ends
module ehp_assertions (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       cfg_select_n,
	input wire logic       cfg_valid,
	input wire logic       cfg_last,
	input wire logic [7:0] dev_select,
	input wire logic       dev_emulating,
	input wire logic       dev_configured
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// ************************************************************
	// Framing and pacing of link bytes
	// ************************************************************
	valid_in_frame_a: assert property (cfg_valid |-> !cfg_select_n)
		else $error("valid pulse outside select window");
	frame_len_a: assert property ($fell(cfg_select_n) |->
		!cfg_select_n [*2] ##1 cfg_select_n)
		else $error("select window not two cycles");
	valid_second_a: assert property ($fell(cfg_select_n) |=>
		cfg_valid && !cfg_select_n)
		else $error("valid not in second select cycle");
	access_gap_a: assert property ($rose(cfg_select_n) |->
		cfg_select_n [*4])
		else $error("gap between bytes too short");
	settle_wait_a: assert property (cfg_valid && cfg_last |=>
		cfg_select_n [*8] ##1 cfg_select_n [*8])
		else $error("access during settle time");

	// ************************************************************
	// Default hold and switch to loaded configuration
	// ************************************************************
	switch_last_a: assert property (dev_emulating && !dev_configured &&
		cfg_valid && !cfg_select_n && cfg_last |=> dev_configured)
		else $error("no switch after final write");
	hold_default_a: assert property (dev_emulating && !dev_configured &&
		!(cfg_valid && !cfg_select_n && cfg_last) |=> !dev_configured)
		else $error("switch without final write");
	stay_config_a: assert property (dev_configured |=> dev_configured)
		else $error("configured dropped");
	select_stable_a: assert property ((dev_emulating && !dev_configured)
		##1 (dev_emulating && !dev_configured) |-> $stable(dev_select))
		else $error("default select changed before switch");
	code_table_a: assert property (dev_emulating && !dev_configured |->
		dev_select inside {8'h80, 8'h82, 8'h05, 8'h97, 8'h91, 8'h93})
		else $error("default select not a table code");

	// Main scenarios
	cover property (cfg_valid && cfg_last && dev_emulating);
	cover property ($rose(dev_configured) && dev_emulating);
	cover property ($rose(dev_configured) && !dev_emulating);
endmodule : ehp_assertions

// ---- bench/tb_top.sv ----
// Self-checking bench joining host and device ends over the link
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ehp_pkg::*;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  sig_cfg;
	logic [2:0]  straps = 3'h0;
	logic        ss = 1'b0;
	logic        sp = 1'b0;
	logic [1:0]  sm = 2'h0;
	logic        lp = 1'b0;
	logic        nvm_v = 1'b0;
	logic [7:0]  nvm_sel = 8'h00;
	logic [7:0]  nvm_sub = 8'h00;
	logic [15:0] nvm_ext = 16'h0000;
	logic [7:0]  isc;
	logic [7:0]  sub;
	logic [15:0] ext;
	logic        ser_en;
	logic        par_en;
	logic        wack;
	logic        conf;
	int          error_cnt = 0;
	int          cmp_count = 0;
	logic [7:0]  sel_tab [8] = '{SEL_SERIAL, SEL_DEMUX16_DM, SEL_MUX1P16_DM,
		SEL_MUX2P16_DM, SEL_SERIAL_DM, SEL_VENDOR_SER, SEL_NONE, SEL_NONE};

	// Clock at 10 MHz
	always #50 hclk = ~hclk;

	ehp_link_if lnk ();
	ehp_device ehp_device_i (.hclk(hclk), .hresetn(hresetn), .link(lnk),
		.emulation_interface_straps(straps), .serial_sample_mode_strap(ss),
		.serial_select_polarity_strap(sp), .serial_mode_straps(sm),
		.latch_polarity_strap(lp), .nvm_load_valid(nvm_v),
		.nvm_select(nvm_sel), .nvm_sub(nvm_sub), .nvm_ext(nvm_ext),
		.interface_select_code(isc), .sub_config(sub), .ext_config(ext),
		.serial_port_enable(ser_en), .parallel_port_enable(par_en),
		.wait_ack_enable(wack), .configured(conf));
	ehp_host ehp_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link(lnk),
		.signalling_config(sig_cfg));
	ehp_assertions ehp_assertions_i (.hclk(hclk), .hresetn(hresetn),
		.cfg_select_n(lnk.cfg_select_n), .cfg_valid(lnk.cfg_valid),
		.cfg_last(lnk.cfg_last), .dev_select(lnk.dev_select),
		.dev_emulating(lnk.dev_emulating),
		.dev_configured(lnk.dev_configured));

	// Verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One single AHB-Lite transfer, address phase then data phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : ahb

	task automatic send(input logic [1:0] i, input logic [7:0] b,
		input logic l);
		logic [31:0] r;
		ahb(1'b1, REG_CTRL, {15'h0, l, b, 6'h0, i}, r);
	endtask : send

	// Poll status until the link byte and any settle time are done
	task automatic idle;
		logic [31:0] st;
		st = 32'h1;
		for (int i = 0; i < 80 && st[STAT_BUSY_BIT] !== 1'b0; i++)
			ahb(1'b0, REG_STATUS, 32'h0, st);
		chk("busy", 32'h0, st[STAT_BUSY_BIT]);
	endtask : idle

	// Reset with one strap pattern, check defaults, then configure
	task automatic run_pat(input int p);
		logic [7:0]  code, dflt, own, wsub, lo, hi, msk;
		logic [31:0] st;
		logic        emul, par;
		emul = p < 6;
		par = p inside {1, 2, 3};
		code = sel_tab[p];
		hresetn <= 1'b0;
		straps <= p[2:0];
		{ss, sp, sm, lp} <= 5'($urandom);
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		dflt = (p == 5) ? {2'b00, ss, sp, 2'b00, sm} :
			(p == 2) ? {5'h0, lp, 2'b00} : 8'h00;
		chk("select", code, isc);
		chk("sub", dflt, sub);
		chk("ext", 32'h0, ext);
		chk("ser_en", emul && !par, ser_en);
		chk("par_en", emul && par, par_en);
		chk("wait_ack", 32'h0, wack);
		chk("conf", 32'h0, conf);
		if (!emul) begin
			{nvm_sel, nvm_sub, nvm_ext} <= $urandom;
			nvm_v <= 1'b1;
			@(posedge hclk);
			nvm_v <= 1'b0;
			repeat (3) @(posedge hclk);
			chk("conf", 32'h1, conf);
			chk("nvm_sel", nvm_sel, isc);
			chk("nvm_sub", nvm_sub, sub);
			chk("nvm_ext", nvm_ext, ext);
			chk("wait_ack", 32'h1, wack);
		end else begin
			ahb(1'b0, REG_STATUS, 32'h0, st);
			chk("emul", 32'h1, st[STAT_EMUL_BIT]);
			chk("st_sel", code, st[15:8]);
			send(IDX_SELECT, par ? SEL_SERIAL : SEL_DEMUX16_DM, 1'b0);
			idle();
			ahb(1'b0, REG_STATUS, 32'h0, st);
			chk("refused", 32'h1, st[STAT_REFU_BIT]);
			{lo, hi, wsub} = 24'($urandom);
			own = (p == 0 || p == 4) ? code ^ SER_DM_MASK : code;
			send(IDX_EXT_LO, lo, 1'b0);
			send(IDX_EXT_LO, ~lo, 1'b0);
			idle();
			send(IDX_EXT_HI, hi, 1'b0);
			idle();
			send(IDX_SELECT, own, 1'b0);
			idle();
			ahb(1'b0, REG_STATUS, 32'h0, st);
			chk("refused", 32'h0, st[STAT_REFU_BIT]);
			chk("early", 32'h0, conf);
			chk("early_sel", code, isc);
			send(IDX_SUB, wsub, 1'b1);
			idle();
			msk = par ? 8'h20 : 8'h10;
			chk("conf", 32'h1, conf);
			chk("wait_ack", 32'h1, wack);
			chk("sel", own, isc);
			chk("sub", (wsub & ~msk) | (dflt & msk), sub);
			chk("ext", {hi, lo}, ext);
			chk("ser_cfg", !par, ser_en);
			ahb(1'b0, REG_SIGCFG, 32'h0, st);
			chk("sigcfg", {24'h0, wsub}, st);
			ahb(1'b0, 8'h0c, 32'h0, st);
			chk("unmapped", 32'h0, st);
		end
	endtask : run_pat

	// Main sequence: every strap pattern, each behind its own reset
	initial begin
		void'($urandom(32'h4427));
		for (int p = 0; p < 8; p++)
			run_pat(p);
		summarize();
	end

	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge hclk);
		error_cnt++;
		$display("mismatch watchdog expected done seen hang");
		summarize();
	end
endmodule : tb_top

// ---- design/ehp_device.sv ----
// Device end: strap decode, emulation defaults and configuration switch
// Operation
// - Host ports disabled until device is configured
// - Sub-configuration loaded from memory contents
// - Emulation enables default port before configuration
// - Straps 000/100/101 give 0x80/0x82/0x05
// - Straps 001 give parallel code 0x97
// - Straps 010/011 give codes 0x91/0x93
// - Straps 110/111 use real attached memory
// - Host keeps interface type, may toggle direct
// - Plain serial defaults all sub bits zero
// - Vendor serial bits taken from serial straps
// - Parallel defaults listed sub bits to zero
// - Latch polarity strap only in one-phase mode
// - Parallel extended sub-configuration defaults to zero
// - Switch to loaded set after final write
// - Select and chip-select polarity stay default; device keeps the shadow's bit, host signalling_config takes the written byte
// - Host changes signalling only while deselected
// - Wait-acknowledge disabled under emulation defaults
// - Host paces cycles to worst-case timing
// - Host waits 1.5us after final write
// - Either enable strap low selects emulation
//
// Our own choices: register access over AHB-Lite and the address map.
module ehp_device
	import ehp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	ehp_link_if.device       link,
	input  wire logic [2:0]  emulation_interface_straps,
	input  wire logic        serial_sample_mode_strap,
	input  wire logic        serial_select_polarity_strap,
	input  wire logic [1:0]  serial_mode_straps,
	input  wire logic        latch_polarity_strap,
	input  wire logic        nvm_load_valid,
	input  wire logic [7:0]  nvm_select,
	input  wire logic [7:0]  nvm_sub,
	input  wire logic [15:0] nvm_ext,
	output logic      [7:0]  interface_select_code,
	output logic      [7:0]  sub_config,
	output logic      [15:0] ext_config,
	output logic             serial_port_enable,
	output logic             parallel_port_enable,
	output logic             wait_ack_enable,
	output logic             configured
);
	import ehp_pkg::*;

	typedef enum logic [1:0] {
		ST_SAMPLE,
		ST_DEFAULTS,
		ST_AWAIT_NVM,
		ST_LOADED
	} ehp_dev_state_t;

	// ************************************************************
	// Strap synchroniser and one-time capture
	// ************************************************************
	logic [7:0]     strap_raw;
	logic [7:0]     strap_meta_reg;
	logic [7:0]     strap_sync_reg;
	logic [7:0]     strap_reg;
	logic [1:0]     wait_cnt_reg;
	ehp_dev_state_t state_reg;
	ehp_dev_state_t state_next;

	assign strap_raw = {latch_polarity_strap, serial_sample_mode_strap,
		serial_select_polarity_strap, serial_mode_straps,
		emulation_interface_straps};

	// Two flip-flops before any logic looks at the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_meta_reg <= 8'h00;
			strap_sync_reg <= 8'h00;
		end else begin
			strap_meta_reg <= strap_raw;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// Wait for the synchroniser to fill after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wait_cnt_reg <= 2'h0;
		else if (state_reg == ST_SAMPLE)
			wait_cnt_reg <= wait_cnt_reg + 2'h1;
	end

	// Capture once, then hold until the next reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			strap_reg <= 8'h00;
		else if (state_reg == ST_SAMPLE && wait_cnt_reg == 2'(SYNC_CYC))
			strap_reg <= strap_sync_reg;
	end

	// ************************************************************
	// Default selection and sub-configuration
	// ************************************************************
	logic [7:0]  strap_cur;
	logic        emul_mode;
	logic        cap_emul;
	logic [7:0]  def_sel;
	logic [7:0]  def_sub;

	assign strap_cur = (state_reg == ST_SAMPLE) ? strap_sync_reg : strap_reg;
	assign emul_mode = ~(strap_cur[2] & strap_cur[1]);
	assign cap_emul  = ~(strap_sync_reg[2] & strap_sync_reg[1]);

	// Decode the emulation straps into a select code and sub bits
	always_comb begin
		def_sel = SEL_NONE;
		def_sub = SUB_RESET;
		unique case (strap_cur[2:0])
			STRAP_SERIAL:  def_sel = SEL_SERIAL;
			STRAP_SER_DM:  def_sel = SEL_SERIAL_DM;
			STRAP_VENDOR: begin
				def_sel = SEL_VENDOR_SER;
				def_sub[SUB_SAMPLE_BIT] = strap_cur[6];
				def_sub[SUB_SELPOL_BIT] = strap_cur[5];
				def_sub[1:0]            = strap_cur[4:3];
			end
			STRAP_DEMUX16: def_sel = SEL_DEMUX16_DM;
			STRAP_MUX1P16: begin
				def_sel = SEL_MUX1P16_DM;
				def_sub[SUB_LEPOL_BIT] = strap_cur[7];
			end
			STRAP_MUX2P16: def_sel = SEL_MUX2P16_DM;
			default:       def_sel = SEL_NONE;
		endcase
	end

	// ************************************************************
	// Emulated configuration shadow
	// ************************************************************
	logic [7:0]  sh_sel_reg;
	logic [7:0]  sh_sub_reg;
	logic [15:0] sh_ext_reg;
	logic [7:0]  sh_sel_next;
	logic [7:0]  sh_sub_next;
	logic [15:0] sh_ext_next;
	logic        wr_take;
	logic        wr_final;

	assign wr_take  = (state_reg == ST_DEFAULTS) && link.cfg_valid &&
		!link.cfg_select_n;
	assign wr_final = wr_take && link.cfg_last;

	// Fold the byte of this cycle into the shadow
	always_comb begin
		sh_sel_next = sh_sel_reg;
		sh_sub_next = sh_sub_reg;
		sh_ext_next = sh_ext_reg;
		if (wr_take) begin
			unique case (link.cfg_index)
				IDX_SELECT: sh_sel_next       = link.cfg_data;
				IDX_SUB:    sh_sub_next       = link.cfg_data;
				IDX_EXT_LO: sh_ext_next[7:0]  = link.cfg_data;
				IDX_EXT_HI: sh_ext_next[15:8] = link.cfg_data;
			endcase
		end
	end

	// Shadow starts from the defaults so unwritten bytes keep them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_sel_reg <= SEL_NONE;
			sh_sub_reg <= SUB_RESET;
			sh_ext_reg <= EXT_RESET;
		end else if (state_reg != ST_DEFAULTS) begin
			sh_sel_reg <= def_sel;
			sh_sub_reg <= def_sub;
			sh_ext_reg <= EXT_RESET;
		end else begin
			sh_sel_reg <= sh_sel_next;
			sh_sub_reg <= sh_sub_next;
			sh_ext_reg <= sh_ext_next;
		end
	end

	// ************************************************************
	// Mode sequencing
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_SAMPLE:
				if (wait_cnt_reg == 2'(SYNC_CYC))
					state_next = cap_emul ? ST_DEFAULTS : ST_AWAIT_NVM;
			ST_DEFAULTS:
				if (wr_final)
					state_next = ST_LOADED;
			ST_AWAIT_NVM:
				if (nvm_load_valid)
					state_next = ST_LOADED;
			ST_LOADED:
				state_next = ST_LOADED;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			state_reg <= ST_SAMPLE;
		else
			state_reg <= state_next;
	end

	// ************************************************************
	// Active configuration and port enables
	// ************************************************************
	logic [7:0] load_sub;

	// Keep the select and chip-select polarity held in the shadow before this byte
	always_comb begin
		load_sub = sh_sub_next;
		if (ehp_is_parallel(sh_sel_reg))
			load_sub[SUB_CSPOL_BIT] = sh_sub_reg[SUB_CSPOL_BIT];
		else
			load_sub[SUB_SELPOL_BIT] = sh_sub_reg[SUB_SELPOL_BIT];
	end

	// Active set: defaults during emulation, then loaded values
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			interface_select_code <= SEL_NONE;
			sub_config            <= SUB_RESET;
			ext_config            <= EXT_RESET;
		end else if (state_next == ST_DEFAULTS) begin
			interface_select_code <= def_sel;
			sub_config            <= def_sub;
			ext_config            <= EXT_RESET;
		end else if (wr_final) begin
			interface_select_code <= sh_sel_next;
			sub_config            <= load_sub;
			ext_config            <= sh_ext_next;
		end else if (state_reg == ST_AWAIT_NVM && nvm_load_valid) begin
			interface_select_code <= nvm_select;
			sub_config            <= nvm_sub;
			ext_config            <= nvm_ext;
		end
	end

	// Ports stay off until a configuration or emulation default exists
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_port_enable   <= 1'b0;
			parallel_port_enable <= 1'b0;
			wait_ack_enable      <= 1'b0;
			configured           <= 1'b0;
		end else if (state_next == ST_DEFAULTS) begin
			serial_port_enable   <= !ehp_is_parallel(def_sel);
			parallel_port_enable <= ehp_is_parallel(def_sel);
			wait_ack_enable      <= 1'b0;
			configured           <= 1'b0;
		end else if (state_next == ST_LOADED) begin
			serial_port_enable   <= !ehp_is_parallel(interface_select_code);
			parallel_port_enable <= ehp_is_parallel(interface_select_code);
			wait_ack_enable      <= 1'b1;
			configured           <= 1'b1;
		end else begin
			serial_port_enable   <= 1'b0;
			parallel_port_enable <= 1'b0;
			wait_ack_enable      <= 1'b0;
			configured           <= 1'b0;
		end
	end

	// Status towards the host
	assign link.dev_select     = interface_select_code;
	assign link.dev_emulating  = emul_mode && (state_reg != ST_SAMPLE);
	assign link.dev_configured = configured;

endmodule : ehp_device

// ---- design/ehp_host.sv ----
// Host end: AHB-Lite controlled writer of emulated configuration bytes
module ehp_host
	import ehp_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	ehp_link_if.host         link,
	output logic      [7:0]  signalling_config
);
	import ehp_pkg::*;

	localparam int CNT_W = 5;

	typedef enum logic [2:0] {
		H_IDLE,
		H_SELECT,
		H_STROBE,
		H_GAP,
		H_SETTLE
	} ehp_host_state_t;

	ehp_host_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             ap_write_reg;
	logic [7:0]       ap_addr_reg;
	logic             ap_valid_reg;
	logic             ctrl_wr;
	logic             launch;
	logic             refuse;
	logic             refused_reg;
	logic             last_reg;
	logic [7:0]       pend_sig_reg;
	logic [7:0]       wr_byte;
	logic [31:0]      rd_value;

	// ************************************************************
	// AHB-Lite slave, zero wait states
	// ************************************************************
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Register the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_reg <= 1'b0;
			ap_write_reg <= 1'b0;
			ap_addr_reg  <= 8'h00;
		end else if (hready) begin
			ap_valid_reg <= hsel && htrans[1];
			ap_write_reg <= hwrite;
			ap_addr_reg  <= haddr[7:0];
		end
	end

	// Read data is prepared at the address phase
	always_comb begin
		rd_value = 32'h0000_0000;
		unique case (haddr[7:0])
			REG_STATUS: begin
				rd_value[STAT_BUSY_BIT] = (state_reg != H_IDLE);
				rd_value[STAT_CONF_BIT] = link.dev_configured;
				rd_value[STAT_EMUL_BIT] = link.dev_emulating;
				rd_value[STAT_REFU_BIT] = refused_reg;
				rd_value[STAT_SEL_LSB +: 8] = link.dev_select;
			end
			REG_SIGCFG: rd_value[7:0] = signalling_config;
			default:    rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= rd_value;
	end

	// ************************************************************
	// Byte launch and type guard
	// ************************************************************
	assign ctrl_wr = ap_valid_reg && ap_write_reg && (ap_addr_reg == REG_CTRL);
	assign launch  = ctrl_wr && (state_reg == H_IDLE);
	assign refuse  = launch &&
		(hwdata[CTRL_IDX_LSB +: 2] == IDX_SELECT) &&
		(ehp_family(hwdata[CTRL_DATA_LSB +: 8]) !=
		 ehp_family(link.dev_select));
	assign wr_byte = refuse ? link.dev_select : hwdata[CTRL_DATA_LSB +: 8];

	// Latch the byte to send and the pending signalling change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link.cfg_index <= IDX_SELECT;
			link.cfg_data  <= 8'h00;
			link.cfg_last  <= 1'b0;
			last_reg       <= 1'b0;
			pend_sig_reg   <= SUB_RESET;
		end else if (launch) begin
			link.cfg_index <= hwdata[CTRL_IDX_LSB +: 2];
			link.cfg_data  <= wr_byte;
			link.cfg_last  <= hwdata[CTRL_LAST_BIT];
			last_reg       <= hwdata[CTRL_LAST_BIT];
			if (hwdata[CTRL_IDX_LSB +: 2] == IDX_SUB)
				pend_sig_reg <= wr_byte;
		end
	end

	// Sticky refusal; a new refusal wins over the clearing launch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			refused_reg <= 1'b0;
		else if (refuse)
			refused_reg <= 1'b1;
		else if (launch)
			refused_reg <= 1'b0;
	end

	// ************************************************************
	// Link sequencing
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= H_IDLE;
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				H_IDLE:
					if (launch)
						state_reg <= H_SELECT;
				H_SELECT:
					state_reg <= H_STROBE;
				H_STROBE: begin
					state_reg <= H_GAP;
					cnt_reg   <= CNT_W'(GAP_CYC - 1);
				end
				H_GAP:
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - CNT_W'(1);
					else if (last_reg) begin
						state_reg <= H_SETTLE;
						cnt_reg   <= CNT_W'(SETTLE_CYC - 1);
					end else
						state_reg <= H_IDLE;
				H_SETTLE:
					if (cnt_reg != '0)
						cnt_reg <= cnt_reg - CNT_W'(1);
					else
						state_reg <= H_IDLE;
			endcase
		end
	end

	// Bus signalling follows the new setup only while deselected
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			signalling_config <= SUB_RESET;
		else if (state_reg == H_SETTLE)
			signalling_config <= pend_sig_reg;
	end

	assign link.cfg_select_n = !(state_reg == H_SELECT ||
		state_reg == H_STROBE);
	assign link.cfg_valid    = (state_reg == H_STROBE);

endmodule : ehp_host

// ---- design/ehp_link_if.sv ----
// Link between the configuring host and the device port logic
interface ehp_link_if;
	logic       cfg_select_n;
	logic       cfg_valid;
	logic [1:0] cfg_index;
	logic [7:0] cfg_data;
	logic       cfg_last;
	logic [7:0] dev_select;
	logic       dev_emulating;
	logic       dev_configured;

	modport device (
		input  cfg_select_n, cfg_valid, cfg_index, cfg_data, cfg_last,
		output dev_select, dev_emulating, dev_configured
	);
	modport host (
		output cfg_select_n, cfg_valid, cfg_index, cfg_data, cfg_last,
		input  dev_select, dev_emulating, dev_configured
	);
endinterface : ehp_link_if

// ---- design/ehp_pkg.sv ----
// Shared constants, codes and helpers for the emulation host port defaults
package ehp_pkg;

	// ************************************************************
	// Interface select codes and strap patterns
	// ************************************************************
	localparam logic [7:0] SEL_SERIAL     = 8'h80;
	localparam logic [7:0] SEL_SERIAL_DM  = 8'h82;
	localparam logic [7:0] SEL_VENDOR_SER = 8'h05;
	localparam logic [7:0] SEL_DEMUX16_DM = 8'h97;
	localparam logic [7:0] SEL_MUX1P16_DM = 8'h91;
	localparam logic [7:0] SEL_MUX2P16_DM = 8'h93;
	localparam logic [7:0] SEL_NONE       = 8'h00;
	localparam logic [7:0] PAR_DM_MASK    = 8'h10;
	localparam logic [7:0] SER_DM_MASK    = 8'h02;
	localparam logic [3:0] PAR_FAMILY     = 4'h9;
	localparam logic [3:0] PAR_FAMILY_ND  = 4'h8;

	localparam logic [2:0] STRAP_SERIAL   = 3'h0;
	localparam logic [2:0] STRAP_DEMUX16  = 3'h1;
	localparam logic [2:0] STRAP_MUX1P16  = 3'h2;
	localparam logic [2:0] STRAP_MUX2P16  = 3'h3;
	localparam logic [2:0] STRAP_SER_DM   = 3'h4;
	localparam logic [2:0] STRAP_VENDOR   = 3'h5;

	// ************************************************************
	// Sub-configuration fields and reset values
	// ************************************************************
	localparam logic [7:0]  SUB_RESET        = 8'h00;
	localparam logic [15:0] EXT_RESET        = 16'h0000;
	localparam int          SUB_SAMPLE_BIT   = 5;
	localparam int          SUB_SELPOL_BIT   = 4;
	localparam int          SUB_CSPOL_BIT    = 5;
	localparam int          SUB_LEPOL_BIT    = 2;

	// ************************************************************
	// Link byte indices
	// ************************************************************
	localparam logic [1:0] IDX_SELECT = 2'h0;
	localparam logic [1:0] IDX_SUB    = 2'h1;
	localparam logic [1:0] IDX_EXT_LO = 2'h2;
	localparam logic [1:0] IDX_EXT_HI = 2'h3;

	// ************************************************************
	// Host controller register map
	// ************************************************************
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_STATUS     = 8'h04;
	localparam logic [7:0] REG_SIGCFG     = 8'h08;
	localparam int         CTRL_IDX_LSB   = 0;
	localparam int         CTRL_DATA_LSB  = 8;
	localparam int         CTRL_LAST_BIT  = 16;
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_CONF_BIT  = 1;
	localparam int         STAT_EMUL_BIT  = 2;
	localparam int         STAT_REFU_BIT  = 3;
	localparam int         STAT_SEL_LSB   = 8;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_NS     = 100;
	localparam int SETTLE_NS  = 1500;
	localparam int ACCESS_NS  = 360;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC    = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SYNC_CYC   = 2;

	// Parallel host bus codes sit in the 0x9x row and in 0x8x codes with bit 3 set
	function automatic logic ehp_is_parallel(input logic [7:0] code);
		return (code[7:4] == PAR_FAMILY) ||
			((code[7:4] == PAR_FAMILY_ND) && code[3]);
	endfunction : ehp_is_parallel

	// Interface type with the direct-mapped variant folded away
	function automatic logic [7:0] ehp_family(input logic [7:0] code);
		if (ehp_is_parallel(code))
			return code & ~PAR_DM_MASK;
		else if (code[7])
			return code & ~SER_DM_MASK;
		else
			return code;
	endfunction : ehp_family

endpackage : ehp_pkg
